// [hdl/emsr_pkg.sv]
// Shared constants and carrier types of the MAC status and interrupt block
package emsr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_TQP = 8'h1c;
  localparam logic [7:0] OFS_RSR = 8'h20;
  localparam logic [7:0] OFS_ISR = 8'h24;
  localparam logic [7:0] OFS_IER = 8'h28;
  localparam logic [7:0] OFS_IDR = 8'h2c;
  localparam logic [7:0] OFS_IMR = 8'h30;
  localparam logic [7:0] OFS_PTR = 8'h38;
  // Receive status field positions
  localparam int RSR_NOBUF = 0;
  localparam int RSR_STORED = 1;
  localparam int RSR_FAIL = 2;
  localparam int RSR_W = 3;
  // Interrupt status field positions
  localparam int ISR_MGMT = 0;
  localparam int ISR_RXDONE = 1;
  localparam int ISR_RXOWN = 2;
  localparam int ISR_TXOWN = 3;
  localparam int ISR_TXUND = 4;
  localparam int ISR_RETRY = 5;
  localparam int ISR_TXEXH = 6;
  localparam int ISR_TXDONE = 7;
  localparam int ISR_RXOVR = 10;
  localparam int ISR_BUSERR = 11;
  localparam int ISR_PAUSE = 12;
  localparam int ISR_PZERO = 13;
  localparam int ISR_W = 14;
  localparam logic [ISR_W-1:0] ISR_IMPL = 14'h3cff;
  // Reset values
  localparam logic [RSR_W-1:0] RSR_RST = 3'h0;
  localparam logic [ISR_W-1:0] ISR_RST = 14'h0000;
  localparam logic [ISR_W-1:0] MASK_RST = 14'h0000;
  localparam logic [31:0] TQP_RST = 32'h0000_0000;
  localparam logic [15:0] PAUSE_RST = 16'h0000;
  // Receive buffer availability
  typedef enum logic {RX_HAVE_BUF, RX_WAIT_BUF} emsr_rx_e;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } emsr_bus_s;
  // Event strobes from the DMA, MAC and management engine
  typedef struct packed {
    logic mgmt_done;
    logic rx_stored;
    logic rx_owned_desc;
    logic rx_desc_ok;
    logic rx_frame_start;
    logic store_fail;
    logic tx_owned_desc;
    logic tx_late;
    logic tx_bus_err;
    logic tx_owned_mid;
    logic retry_limit;
    logic tx_exhausted;
    logic tx_done;
    logic bus_err;
    logic pause_rx;
    logic pause_tick;
  } emsr_evt_s;
endpackage

// [hdl/emsr_status_irq.sv]
// MAC status, interrupt and transmit queue pointer registers
// Operation
// R1: queue pointer reads first descriptor of frame
// R2: receive status write one clears, never sets
// R3: no-buffer flag set on every failed fetch
// R4: refetch descriptor each new frame until owned
// R5: frame-stored flag set after frame stored
// R6: store-failed flag set, buffer recovered
// R7: management done event; status clears on read
// R8: receive-complete event per stored frame
// R9: owned descriptor events, receive and transmit
// R10: underrun on late, error, mid-frame, pointer write
// R11: retry-limit event, cleared on read
// R12: transmit-exhausted event on mid-frame run-out
// R13: transmit-complete event per sent frame
// R14: overrun event with store-failed flag
// R15: bus-error event on DMA error response
// R16: pause-received event on valid pause frame
// R17: pause-expired event when pause time hits zero
// R18: enable register unmasks set bits
// R19: disable register masks set bits
// R20: pointer written only while transmit idle
// R21: mask readable as read-only register
// R22: interrupt while unmasked flag set
`timescale 1ns/1ps
module emsr_status_irq (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire emsr_pkg::emsr_bus_s bus_i,
  output logic [31:0] rdata_o,
  input wire emsr_pkg::emsr_evt_s evt_i,
  input wire logic [15:0] pause_quanta_i,
  input wire logic [31:0] tx_next_ptr_i,
  input wire logic tx_active_i,
  output logic [31:0] tx_queue_ptr_o,
  output logic rx_refetch_o,
  output logic rx_buf_recover_o,
  output logic irq_o
);
  import emsr_pkg::*;

  logic [RSR_W-1:0] rsr_reg;
  logic [RSR_W-1:0] rsr_next;
  logic [ISR_W-1:0] isr_reg;
  logic [ISR_W-1:0] isr_next;
  logic [ISR_W-1:0] mask_reg;
  logic [ISR_W-1:0] mask_next;
  logic [31:0] tqp_reg;
  logic [31:0] tqp_next;
  logic [15:0] pause_reg;
  logic [15:0] pause_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic irq_reg;
  logic refetch_reg;
  logic recover_reg;
  emsr_rx_e rx_st_reg;
  emsr_rx_e rx_st_next;

  // Address decode
  wire wr_tqp = bus_i.wr && (bus_i.addr == OFS_TQP);
  wire wr_rsr = bus_i.wr && (bus_i.addr == OFS_RSR);
  wire wr_ier = bus_i.wr && (bus_i.addr == OFS_IER);
  wire wr_idr = bus_i.wr && (bus_i.addr == OFS_IDR);
  wire rd_isr = bus_i.rd && (bus_i.addr == OFS_ISR);
  // R20 pointer write guard; writes during transmit are dropped
  wire tqp_take = wr_tqp && !tx_active_i;

  // R17 pause count reaches zero on a tick
  wire pause_zero = evt_i.pause_tick && (pause_reg == 16'h0001) && !evt_i.pause_rx;

  // Receive status set terms
  logic [RSR_W-1:0] rsr_set;
  // R3 no-buffer on every failed fetch
  assign rsr_set[RSR_NOBUF] = evt_i.rx_owned_desc;
  // R5 frame stored flag
  assign rsr_set[RSR_STORED] = evt_i.rx_stored;
  // R6 store failure flag
  assign rsr_set[RSR_FAIL] = evt_i.store_fail;

  // Interrupt status set terms
  logic [ISR_W-1:0] isr_set;
  // R7 management done
  assign isr_set[ISR_MGMT] = evt_i.mgmt_done;
  // R8 receive complete
  assign isr_set[ISR_RXDONE] = evt_i.rx_stored;
  // R9 owned descriptor read
  assign isr_set[ISR_RXOWN] = evt_i.rx_owned_desc;
  assign isr_set[ISR_TXOWN] = evt_i.tx_owned_desc;
  // R10 any underrun cause
  assign isr_set[ISR_TXUND] = evt_i.tx_late | evt_i.tx_bus_err | evt_i.tx_owned_mid | tqp_take;
  // R11 retry limit
  assign isr_set[ISR_RETRY] = evt_i.retry_limit;
  // R12 buffers exhausted
  assign isr_set[ISR_TXEXH] = evt_i.tx_exhausted;
  // R13 transmit complete
  assign isr_set[ISR_TXDONE] = evt_i.tx_done;
  assign isr_set[9:8] = 2'h0;
  // R14 overrun tracks store failure
  assign isr_set[ISR_RXOVR] = evt_i.store_fail;
  // R15 DMA bus error
  assign isr_set[ISR_BUSERR] = evt_i.bus_err;
  // R16 pause frame received
  assign isr_set[ISR_PAUSE] = evt_i.pause_rx;
  // R17 pause expired
  assign isr_set[ISR_PZERO] = pause_zero;

  // R2 write one clears, set wins over clear
  assign rsr_next = (rsr_reg & ~(wr_rsr ? bus_i.wdata[RSR_W-1:0] : RSR_RST)) | rsr_set;
  // R7 clear on read; an event in the read cycle survives
  assign isr_next = ((rd_isr ? ISR_RST : isr_reg) | isr_set) & ISR_IMPL;
  // R18 enable sets mask, R19 disable clears it; zero bits keep
  assign mask_next = ((mask_reg | (wr_ier ? bus_i.wdata[ISR_W-1:0] : MASK_RST))
    & ~(wr_idr ? bus_i.wdata[ISR_W-1:0] : MASK_RST)) & ISR_IMPL;
  // R1 pointer moves to first descriptor of next frame
  assign tqp_next = tqp_take ? {bus_i.wdata[31:2], 2'h0} :
    evt_i.tx_done ? {tx_next_ptr_i[31:2], 2'h0} : tqp_reg;
  // Pause timer load and countdown
  assign pause_next = evt_i.pause_rx ? pause_quanta_i :
    (evt_i.pause_tick && pause_reg != PAUSE_RST) ? pause_reg - 16'h0001 : pause_reg;
  // R4 wait for an owned descriptor after a failed fetch
  assign rx_st_next = evt_i.rx_owned_desc ? RX_WAIT_BUF :
    evt_i.rx_desc_ok ? RX_HAVE_BUF : rx_st_reg;

  // Read data mux; unmapped and write-only offsets read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (!bus_i.rd) begin
      rdata_next = 32'h0000_0000;
    end else if (bus_i.addr == OFS_TQP) begin
      rdata_next = tqp_reg;
    end else if (bus_i.addr == OFS_RSR) begin
      rdata_next = {29'h0, rsr_reg};
    end else if (bus_i.addr == OFS_ISR) begin
      rdata_next = {18'h0, isr_reg};
    end else if (bus_i.addr == OFS_IMR) begin
      // R21 mask read-back
      rdata_next = {18'h0, mask_reg};
    end else if (bus_i.addr == OFS_PTR) begin
      rdata_next = {16'h0, pause_reg};
    end
  end

  // Status and mask state
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rsr_reg <= RSR_RST;
      isr_reg <= ISR_RST;
      mask_reg <= MASK_RST;
    end else begin
      rsr_reg <= rsr_next;
      isr_reg <= isr_next;
      mask_reg <= mask_next;
    end
  end

  // Pointer, timer and receive state
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tqp_reg <= TQP_RST;
      pause_reg <= PAUSE_RST;
      rx_st_reg <= RX_HAVE_BUF;
    end else begin
      tqp_reg <= tqp_next;
      pause_reg <= pause_next;
      rx_st_reg <= rx_st_next;
    end
  end

  // Registered outputs; irq built from next state so it tracks the flags
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
      refetch_reg <= 1'b0;
      recover_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      // R22 unmasked flag drives interrupt
      irq_reg <= |(isr_next & mask_next);
      // R4 refetch at frame start while waiting
      refetch_reg <= evt_i.rx_frame_start && (rx_st_reg == RX_WAIT_BUF);
      // R6 give the buffer back
      recover_reg <= evt_i.store_fail;
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign rx_refetch_o = refetch_reg;
  assign rx_buf_recover_o = recover_reg;
  assign tx_queue_ptr_o = tqp_reg;

  // Checks on the block's own registers and outputs
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_tqp_frame;
    evt_i.tx_done && !tqp_take |=> tx_queue_ptr_o == {$past(tx_next_ptr_i[31:2]), 2'h0};
  endproperty
  a_tqp_frame: assert property (p_tqp_frame) else $error("pointer not advanced"); // R1

  property p_rsr_clear;
    wr_rsr && bus_i.wdata[RSR_FAIL] && !evt_i.store_fail |=> !rsr_reg[RSR_FAIL];
  endproperty
  a_rsr_clear: assert property (p_rsr_clear) else $error("fail flag not cleared"); // R2

  property p_rsr_noset;
    !rsr_reg[RSR_STORED] && !evt_i.rx_stored |=> !rsr_reg[RSR_STORED];
  endproperty
  a_rsr_noset: assert property (p_rsr_noset) else $error("flag set by write"); // R2

  property p_nobuf;
    evt_i.rx_owned_desc |=> rsr_reg[RSR_NOBUF] && isr_reg[ISR_RXOWN];
  endproperty
  a_nobuf: assert property (p_nobuf) else $error("failed fetch not flagged"); // R3

  property p_refetch;
    evt_i.rx_owned_desc ##1 (evt_i.rx_frame_start && !evt_i.rx_desc_ok) |=> rx_refetch_o;
  endproperty
  a_refetch: assert property (p_refetch) else $error("no refetch"); // R4

  property p_fail;
    evt_i.store_fail |=> rsr_reg[RSR_FAIL] && rx_buf_recover_o && isr_reg[ISR_RXOVR];
  endproperty
  a_fail: assert property (p_fail) else $error("store failure not handled"); // R6

  property p_rd_clear;
    rd_isr && isr_set == ISR_RST |=> isr_reg == ISR_RST ##0 rdata_o == {18'h0, $past(isr_reg)};
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read did not clear"); // R7

  property p_underrun;
    tqp_take |=> isr_reg[ISR_TXUND];
  endproperty
  a_underrun: assert property (p_underrun) else $error("pointer write no underrun"); // R10

  property p_pzero;
    pause_zero |=> isr_reg[ISR_PZERO] && pause_reg == PAUSE_RST;
  endproperty
  a_pzero: assert property (p_pzero) else $error("pause expiry missed"); // R17

  property p_enable;
    wr_ier |=> (mask_reg & ISR_IMPL & $past(bus_i.wdata[ISR_W-1:0])) ==
      (ISR_IMPL & $past(bus_i.wdata[ISR_W-1:0]));
  endproperty
  a_enable: assert property (p_enable) else $error("enable lost"); // R18

  property p_disable;
    wr_idr |=> (mask_reg & $past(bus_i.wdata[ISR_W-1:0])) == MASK_RST;
  endproperty
  a_disable: assert property (p_disable) else $error("disable lost"); // R19

  property p_irq;
    irq_o == |(isr_reg & mask_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch"); // R22

  // Event to flag checks; the three datapath underrun causes share one
  // R5 stored frame raises the stored flag
  property p_stored;
    evt_i.rx_stored |=> rsr_reg[RSR_STORED];
  endproperty
  a_stored: assert property (p_stored) else $error("stored flag missed"); // R5

  // R8 stored frame raises receive complete
  property p_rx_done;
    evt_i.rx_stored |=> isr_reg[ISR_RXDONE];
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("receive complete missed"); // R8

  // R9 owned transmit descriptor event
  property p_tx_own;
    evt_i.tx_owned_desc |=> isr_reg[ISR_TXOWN];
  endproperty
  a_tx_own: assert property (p_tx_own) else $error("tx owned event missed"); // R9

  // R10 each datapath underrun cause
  property p_tx_cause;
    evt_i.tx_late || evt_i.tx_bus_err || evt_i.tx_owned_mid |=> isr_reg[ISR_TXUND];
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("underrun cause missed"); // R10

  // R11 retry limit event
  property p_retry;
    evt_i.retry_limit |=> isr_reg[ISR_RETRY];
  endproperty
  a_retry: assert property (p_retry) else $error("retry limit missed"); // R11

  // R12 buffers exhausted mid-frame
  property p_exhaust;
    evt_i.tx_exhausted |=> isr_reg[ISR_TXEXH];
  endproperty
  a_exhaust: assert property (p_exhaust) else $error("exhausted event missed"); // R12

  // R13 frame sent event
  property p_tx_done;
    evt_i.tx_done |=> isr_reg[ISR_TXDONE];
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("transmit complete missed"); // R13

  // R14 overrun event rises with the fail flag
  property p_overrun;
    $rose(rsr_reg[RSR_FAIL]) |-> isr_reg[ISR_RXOVR];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not with fail flag"); // R14

  // R15 DMA error response
  property p_bus_err;
    evt_i.bus_err |=> isr_reg[ISR_BUSERR];
  endproperty
  a_bus_err: assert property (p_bus_err) else $error("bus error missed"); // R15

  // R16 pause frame event and timer load
  property p_pause_rx;
    evt_i.pause_rx |=> isr_reg[ISR_PAUSE] && pause_reg == $past(pause_quanta_i);
  endproperty
  a_pause_rx: assert property (p_pause_rx) else $error("pause frame missed"); // R16

  // R17 an expired timer must not wrap
  property p_pause_hold;
    evt_i.pause_tick && !evt_i.pause_rx && pause_reg == PAUSE_RST |=> pause_reg == PAUSE_RST;
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pause timer wrapped"); // R17

  // R21 mask read-back shows the live mask
  property p_mask_rd;
    bus_i.rd && bus_i.addr == OFS_IMR |=> rdata_o == {18'h0, $past(mask_reg)};
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask read-back wrong"); // R21

  // R20 refused write keeps the frame pointer
  property p_tqp_hold;
    wr_tqp && tx_active_i && !evt_i.tx_done |=> $stable(tx_queue_ptr_o);
  endproperty
  a_tqp_hold: assert property (p_tqp_hold) else $error("pointer moved while active"); // R20

  // R2 a set beats a write-one clear
  property p_rsr_race;
    rsr_set != RSR_RST |=> (rsr_reg & $past(rsr_set)) == $past(rsr_set);
  endproperty
  a_rsr_race: assert property (p_rsr_race) else $error("status set lost"); // R2

  // R6 recovery pulse only after a failure
  property p_recover_only;
    !evt_i.store_fail |=> !rx_buf_recover_o;
  endproperty
  a_recover_only: assert property (p_recover_only) else $error("spurious recover"); // R6

  // R4 refetch only on a frame start
  property p_refetch_only;
    !evt_i.rx_frame_start |=> !rx_refetch_o;
  endproperty
  a_refetch_only: assert property (p_refetch_only) else $error("spurious refetch"); // R4

  // R18, R19 zero bits leave the mask alone
  property p_mask_keep;
    (wr_ier || wr_idr) && bus_i.wdata[ISR_W-1:0] == MASK_RST |=> $stable(mask_reg);
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("zero write moved mask"); // R18, R19

  // R7 per event bit, a set in the read cycle survives the clear
  for (genvar gi = 0; gi < ISR_W; gi++) begin : g_isr_set
    if (ISR_IMPL[gi]) begin : g_impl
      property p_isr_set;
        @(posedge mclk_i) disable iff (rst_i) isr_set[gi] |=> isr_reg[gi];
      endproperty
      a_isr_set: assert property (p_isr_set) else $error("event bit lost"); // R7
    end
  end

  c_irq_rise: cover property (!irq_o ##1 irq_o);
  c_refetch: cover property (rx_refetch_o);
  c_clear_race: cover property (rd_isr && isr_set != ISR_RST);
  c_pzero: cover property (pause_zero);
  c_set_wins: cover property (wr_rsr && rsr_set != RSR_RST);
endmodule

// [test/emsr_tb.sv]
// Self-checking bench for the MAC status and interrupt registers
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED at %0t: %s", $time, msg); end end
module testbench;
  import emsr_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  emsr_bus_s bus = '0;
  emsr_evt_s evt = '0;
  logic [31:0] rdata;
  logic [15:0] quanta = 16'h0002;
  logic [31:0] next_ptr = 32'h1000_0a57;
  logic tx_active = 1'b0;
  logic [31:0] tqp;
  logic refetch;
  logic recover;
  logic irq;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  // Expected status per event strobe, index = position from the top of the event struct
  localparam logic [31:0] ISR_EXP [16] = '{32'h1, 32'h2, 32'h4, 32'h0, 32'h0, 32'h400, 32'h8,
    32'h10, 32'h10, 32'h10, 32'h20, 32'h40, 32'h80, 32'h800, 32'h1000, 32'h0};
  localparam logic [31:0] RSR_EXP [16] = '{32'h0, 32'h2, 32'h1, 32'h0, 32'h0, 32'h4, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  emsr_status_irq dut_u (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .bus_i(bus),
    .rdata_o(rdata),
    .evt_i(evt),
    .pause_quanta_i(quanta),
    .tx_next_ptr_i(next_ptr),
    .tx_active_i(tx_active),
    .tx_queue_ptr_o(tqp),
    .rx_refetch_o(refetch),
    .rx_buf_recover_o(recover),
    .irq_o(irq)
  );

  // 20 MHz clock
  always #25 mclk_i = ~mclk_i;

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // Single event strobe with the given field set
  function automatic emsr_evt_s ev(input int k);
    ev = emsr_evt_s'(16'h8000 >> k);
  endfunction

  // One-cycle write strobe; effect visible on return
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge mclk_i);
    bus.wr <= 1'b0;
    #1;
  endtask

  // One-cycle read strobe; data checked in the single cycle it stands
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    @(posedge mclk_i);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge mclk_i);
    bus.rd <= 1'b0;
    #1;
    `CHK(rdata, e, m)
  endtask

  // One-cycle event pulse; registered effects visible on return
  task automatic pulse(input emsr_evt_s e);
    @(posedge mclk_i);
    evt <= e;
    @(posedge mclk_i);
    evt <= '0;
    #1;
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    // Reset contents
    rd(OFS_RSR, 32'h0, "rsr reset");
    rd(OFS_ISR, 32'h0, "isr reset");
    rd(OFS_IMR, 32'h0, "mask reset");
    rd(OFS_TQP, 32'h0, "pointer reset");
    // Every event strobe, all masked; flags clear on read or by writing ones
    for (int k = 0; k < 16; k++) begin
      pulse(ev(k));
      `CHK(irq, 1'b0, "irq while masked")
      rd(OFS_ISR, ISR_EXP[k], "isr event bit");
      rd(OFS_ISR, 32'h0, "isr clear on read");
      rd(OFS_RSR, RSR_EXP[k], "rsr flag");
      wr(OFS_RSR, 32'h0);
      rd(OFS_RSR, RSR_EXP[k], "rsr zero write");
      wr(OFS_RSR, 32'hffff_ffff);
      rd(OFS_RSR, 32'h0, "rsr write one clear");
    end
    // Pause timer went 2 to 1 above; the next tick reaches zero
    rd(OFS_PTR, 32'h1, "pause timer");
    pulse(ev(15));
    rd(OFS_ISR, 32'h2000, "pause expired");
    rd(OFS_PTR, 32'h0, "pause timer zero");
    pulse(ev(15));
    rd(OFS_PTR, 32'h0, "timer stays at zero");
    // Repeated failed fetches and refetch on each frame start
    pulse(ev(2));
    wr(OFS_RSR, 32'h1);
    pulse(ev(4));
    `CHK(refetch, 1'b1, "refetch first frame")
    pulse(ev(2));
    rd(OFS_RSR, 32'h1, "no buffer set again");
    pulse(ev(4));
    `CHK(refetch, 1'b1, "refetch second frame")
    pulse(ev(3));
    pulse(ev(4));
    `CHK(refetch, 1'b0, "no refetch once owned")
    pulse(ev(5));
    `CHK(recover, 1'b1, "buffer recovered")
    wr(OFS_RSR, 32'h7);
    rd(OFS_ISR, 32'h404, "isr after fetch tests");
    // Mask set and cleared by the write-only registers
    pulse(ev(12));
    `CHK(irq, 1'b0, "pending but masked")
    wr(OFS_IER, 32'h80);
    `CHK(irq, 1'b1, "unmasked pending")
    wr(OFS_IER, 32'h0);
    `CHK(irq, 1'b1, "zero enable keeps mask")
    wr(OFS_IDR, 32'h0);
    `CHK(irq, 1'b1, "zero disable keeps mask")
    wr(OFS_IDR, 32'h80);
    `CHK(irq, 1'b0, "masked again")
    rd(OFS_IMR, 32'h0, "mask after disable");
    wr(OFS_IER, 32'hffff_ffff);
    rd(OFS_IMR, {18'h0, ISR_IMPL}, "mask all enabled");
    `CHK(irq, 1'b1, "irq all enabled")
    rd(OFS_ISR, 32'h80, "done event");
    `CHK(irq, 1'b0, "irq after clear")
    wr(OFS_IDR, 32'hffff_ffff);
    rd(OFS_IMR, 32'h0, "mask all disabled");
    // Queue pointer follows the frame being sent, software write when idle
    `CHK(tqp, 32'h1000_0a54, "pointer after frame")
    rd(OFS_TQP, 32'h1000_0a54, "pointer read");
    @(posedge mclk_i);
    #1;
    `CHK(rdata, 32'h0, "read data stands one cycle")
    wr(OFS_TQP, 32'h2000_0103);
    rd(OFS_TQP, 32'h2000_0100, "pointer written");
    rd(OFS_ISR, 32'h10, "underrun on pointer write");
    @(posedge mclk_i);
    tx_active <= 1'b1;
    wr(OFS_TQP, 32'h3000_0000);
    rd(OFS_TQP, 32'h2000_0100, "pointer write while active");
    rd(OFS_ISR, 32'h0, "no underrun while active");
    // Write-only and unmapped places read zero
    rd(OFS_IER, 32'h0, "enable reads zero");
    rd(OFS_IDR, 32'h0, "disable reads zero");
    rd(8'h04, 32'h0, "unmapped reads zero");
    // Events in clearing cycles: the set wins over read and write-one clear
    @(posedge mclk_i);
    evt <= ev(2);
    bus.rd <= 1'b1;
    bus.addr <= OFS_ISR;
    @(posedge mclk_i);
    evt <= emsr_evt_s'(ev(2) | ev(4));
    bus.rd <= 1'b0;
    bus.wr <= 1'b1;
    bus.addr <= OFS_RSR;
    bus.wdata <= 32'h1;
    @(posedge mclk_i);
    evt <= '0;
    bus.wr <= 1'b0;
    #1;
    `CHK(refetch, 1'b1, "refetch on next frame start")
    rd(OFS_RSR, 32'h1, "set beats write one clear");
    rd(OFS_ISR, 32'h4, "set beats read clear");
    // Reset in mid-run returns flags, mask, pointer and irq to zero
    wr(OFS_IER, 32'h1);
    pulse(ev(0));
    `CHK(irq, 1'b1, "irq before reset")
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    `CHK(irq, 1'b0, "irq after reset")
    rd(OFS_IMR, 32'h0, "mask after reset");
    rd(OFS_ISR, 32'h0, "isr after reset");
    rd(OFS_TQP, 32'h0, "pointer after reset");
    rd(OFS_RSR, 32'h0, "rsr after reset");
    end_sim();
  end
endmodule
